/* File: fwp_host.sv */
// host-side model that frames instructions on the chip-select and serial-clock pins
module fwp_host (
  // clock
  input wire logic clk,
  // pins and decoded instruction
  output logic cs_n,
  output logic sclk,
  output logic ins_valid,
  output fwp_pkg::fwp_cmd_t ins_code,
  output logic [19:0] ins_addr,
  output logic [6:0] ins_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: deselected, mode 0 clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    ins_valid = 1'b0;
    ins_code = fwp_pkg::cmd_none;
    ins_addr = 20'h0_0000;
    ins_status = 7'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // every pin phase lasts at least three cycles so the synchronisers see each edge
  task automatic frame(input fwp_pkg::fwp_cmd_t c, input int n, input logic [19:0] a,
                       input logic [6:0] st);
    int k;
    cs_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (k = 0; k < n; k++) begin
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    ins_valid <= 1'b1;
    ins_code <= c;
    ins_addr <= a;
    ins_status <= st;
    @(posedge clk);
    // released fields carry junk, not the last value
    ins_valid <= 1'b0;
    ins_code <= fwp_pkg::cmd_other;
    ins_addr <= ~a;
    ins_status <= ~st;
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
  endtask
endmodule

/* File: fwp_pkg.sv */
// shared constants and types for the flash write-protect and power-mode block
package fwp_pkg;
  // array geometry: address width in bits, sizes in bytes
  localparam int ADDR_W = 20;
  localparam logic [20:0] ARRAY_BYTES = 21'h10_0000;
  localparam logic [20:0] SZ_PAGE = 21'h00_0100;
  localparam logic [20:0] SZ_4K = 21'h00_1000;
  localparam logic [20:0] SZ_32K = 21'h00_8000;
  localparam logic [20:0] SZ_64K = 21'h01_0000;

  // frame clocks are counted modulo eight, so three bits suffice
  localparam int BIT_CNT_W = 3;

  // protect status vector layout
  localparam int STAT_W = 7;
  localparam int POS_COMPLEMENT = 6;
  localparam int POS_GRANULARITY = 5;
  localparam int POS_TOP_BOTTOM = 4;
  localparam int POS_LEVEL_HI = 3;
  localparam int POS_LEVEL_LO = 1;
  localparam int POS_GUARD = 0;
  localparam logic [6:0] STATUS_RST = 7'h00;

  // synchroniser reset levels (pins idle high)
  localparam logic [2:0] SYNC3_IDLE = 3'h7;
  localparam logic [1:0] SYNC2_IDLE = 2'h3;

  // decoded instructions handed over by the front end
  typedef enum logic [3:0] {
    cmd_none, cmd_write_enable, cmd_write_disable, cmd_status_write,
    cmd_status3_write, cmd_page_program, cmd_quad_page_program,
    cmd_sector_wipe, cmd_half_block_erase, cmd_block_erase, cmd_chip_erase,
    cmd_deep_sleep_entry, cmd_wake_and_read_id, cmd_other
  } fwp_cmd_t;

  // power modes
  typedef enum logic [1:0] {pwr_active, pwr_standby, pwr_deep} fwp_pwr_t;
endpackage

/* File: fwp_top.sv */
// write-protect and power-mode control of a serial flash device
//
// Contract
// - while chip select is low the device is enabled and, outside deep power-down, in the active power mode.
// - after chip select rises the device stays active until any internal cycle ends, then stands by.
// - the deep-sleep entry instruction enters deep power-down, left only by wake-and-read-id.
// - in deep power-down every instruction but the wake instruction is ignored.
// - program, erase and status writes are rejected unless the frame held a multiple of eight clocks.
// - data is modified only while the write-enable latch, set by the write-enable instruction, is set.
// - the latch clears at reset, on write-disable and on completion of any status write, program or erase.
// - complement, granularity, top/bottom and three level bits select a read-only part of the array.
// - while write-protect is asserted the protect bits and the guard bit cannot be changed.
// - with complement and granularity 0, levels 1 to 4 protect 64KB to 512KB, top if top/bottom is 0.
// - level 0 without complement protects nothing; gran 0 levels 5 to 7, or gran 1 levels 6 and 7, protect all.
// - with complement 0 and granularity 1, levels 1 to 5 protect 4KB, 8KB, 16KB, 32KB, 32KB.
// - complement with granularity 0 protects the inverse region, level 0 all and levels 5 to 7 none.
// - complement with granularity 1 protects all but the small region, and levels 6 and 7 protect nothing.
// - a program or erase whose target touches any protected byte is ignored.
// - a write-in-progress flag shows a running status-write, program or erase cycle.
module fwp_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // spi pins, asynchronous to clk
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic wp_n,
  // decoded instruction from the front end
  input wire logic ins_valid,
  input wire fwp_pkg::fwp_cmd_t ins_code,
  input wire logic [19:0] ins_addr,
  input wire logic [6:0] ins_status,
  // array engine
  input wire logic op_done,
  output fwp_pkg::fwp_cmd_t op_kind,
  output logic op_start,
  output logic [19:0] op_addr,
  // status and mode
  output logic ins_reject,
  output logic write_enable_latch,
  output logic write_in_progress,
  output logic [6:0] status_bits,
  output fwp_pkg::fwp_pwr_t power_state,
  output logic software_protect_mode,
  output logic hardware_protect_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // size of the protected region and whether it sits at the bottom
  function automatic logic [21:0] fwp_region(input logic [6:0] st);
    logic [2:0] lvl;
    logic [20:0] base;
    lvl = st[fwp_pkg::POS_LEVEL_HI:fwp_pkg::POS_LEVEL_LO];
    base = fwp_pkg::ARRAY_BYTES;
    if (lvl == 3'h0) begin
      base = '0;
    end else if (!st[fwp_pkg::POS_GRANULARITY]) begin
      if (lvl <= 3'h4) begin
        base = fwp_pkg::SZ_64K << (lvl - 3'h1);
      end
    end else if (lvl <= 3'h3) begin
      base = fwp_pkg::SZ_4K << (lvl - 3'h1);
    end else if (lvl <= 3'h5) begin
      base = fwp_pkg::SZ_32K;
    end
    // complement of a top region is a bottom region of the rest
    if (st[fwp_pkg::POS_COMPLEMENT]) begin
      base = fwp_pkg::ARRAY_BYTES - base;
    end
    return {st[fwp_pkg::POS_TOP_BOTTOM] ^ st[fwp_pkg::POS_COMPLEMENT], base};
  endfunction

  // true when the target span of an instruction touches protected bytes
  function automatic logic fwp_hit(input logic [6:0] st, input fwp_pkg::fwp_cmd_t code,
                                   input logic [19:0] addr);
    logic [21:0] reg_info;
    logic [20:0] span;
    logic [20:0] lo;
    logic [20:0] hi;
    reg_info = fwp_region(st);
    unique case (code)
      fwp_pkg::cmd_page_program, fwp_pkg::cmd_quad_page_program: span = fwp_pkg::SZ_PAGE;
      fwp_pkg::cmd_sector_wipe: span = fwp_pkg::SZ_4K;
      fwp_pkg::cmd_half_block_erase: span = fwp_pkg::SZ_32K;
      fwp_pkg::cmd_block_erase: span = fwp_pkg::SZ_64K;
      fwp_pkg::cmd_chip_erase: span = fwp_pkg::ARRAY_BYTES;
      default: span = '0;
    endcase
    lo = {1'b0, addr} & ~(span - 21'h00_0001);
    hi = lo + span - 21'h00_0001;
    if (span == '0 || reg_info[20:0] == '0) begin
      return 1'b0;
    end else if (reg_info[21]) begin
      return lo < reg_info[20:0];
    end else begin
      return hi >= (fwp_pkg::ARRAY_BYTES - reg_info[20:0]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and frame clock count

  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic [1:0] wp_sync;
  logic [2:0] bit_cnt;
  wire cs_low = ~cs_sync[1];
  wire cs_rise = cs_sync[1] & ~cs_sync[2];
  wire cs_fall = ~cs_sync[1] & cs_sync[2];
  wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  wire [2:0] next_bit_cnt = cs_fall ? {2'b00, sclk_rise} : bit_cnt + {2'b00, sclk_rise & cs_low};

  // only stage 1 reads stage 0; edges are taken from stages 1 and 2
  always_ff @(posedge clk) begin
    if (srst) begin
      cs_sync <= fwp_pkg::SYNC3_IDLE;
      sclk_sync <= '0;
      wp_sync <= fwp_pkg::SYNC2_IDLE;
      bit_cnt <= '0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      wp_sync <= {wp_sync[0], wp_n};
      bit_cnt <= next_bit_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending instruction, executed when chip select rises

  fwp_pkg::fwp_cmd_t pend_code;
  logic [19:0] pend_addr;
  logic [6:0] pend_status;

  // the front end may decode early; nothing acts until the frame ends
  always_ff @(posedge clk) begin
    if (srst || cs_rise) begin
      pend_code <= fwp_pkg::cmd_none;
      pend_addr <= '0;
      pend_status <= '0;
    end else if (ins_valid) begin
      pend_code <= ins_code;
      pend_addr <= ins_addr;
      pend_status <= ins_status;
    end
  end

  // execution decode
  wire in_deep = power_state == fwp_pkg::pwr_deep;
  wire free = cs_rise & ~in_deep & ~write_in_progress;
  wire is_status = pend_code == fwp_pkg::cmd_status_write ||
                   pend_code == fwp_pkg::cmd_status3_write;
  wire is_array = pend_code inside {fwp_pkg::cmd_page_program, fwp_pkg::cmd_quad_page_program,
                  fwp_pkg::cmd_sector_wipe, fwp_pkg::cmd_half_block_erase,
                  fwp_pkg::cmd_block_erase, fwp_pkg::cmd_chip_erase};
  wire hit = fwp_hit(status_bits, pend_code, pend_addr);
  wire byte_ok = bit_cnt == '0;
  wire accept = free & (is_status | is_array) & write_enable_latch & byte_ok & ~(is_array & hit);
  wire write_enable_cmd_exec = free & pend_code == fwp_pkg::cmd_write_enable;
  wire write_disable_cmd_exec = free & pend_code == fwp_pkg::cmd_write_disable;
  wire sleep_exec = free & pend_code == fwp_pkg::cmd_deep_sleep_entry;
  wire wake_exec = cs_rise & in_deep & pend_code == fwp_pkg::cmd_wake_and_read_id;
  wire reject = cs_rise & (((is_status | is_array) & ~accept) |
                (in_deep & pend_code != fwp_pkg::cmd_none &
                 pend_code != fwp_pkg::cmd_wake_and_read_id));
  // hardware protect freezes the whole protect vector
  wire [6:0] next_status = hardware_protect_mode ? status_bits : pend_status;
  wire [21:0] cur_region = fwp_region(status_bits);

  // next power mode
  fwp_pkg::fwp_pwr_t next_power;
  always_comb begin
    if (in_deep) begin
      next_power = wake_exec ? fwp_pkg::pwr_active : fwp_pkg::pwr_deep;
    end else if (sleep_exec) begin
      next_power = fwp_pkg::pwr_deep;
    end else if (cs_low || write_in_progress || accept) begin
      next_power = fwp_pkg::pwr_active;
    end else begin
      next_power = fwp_pkg::pwr_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  // engine hand-off and power mode
  always_ff @(posedge clk) begin
    if (srst) begin
      op_start <= 1'b0;
      op_kind <= fwp_pkg::cmd_none;
      op_addr <= '0;
      ins_reject <= 1'b0;
      power_state <= fwp_pkg::pwr_standby;
    end else begin
      op_start <= accept;
      op_kind <= accept ? pend_code : op_kind;
      op_addr <= accept ? pend_addr : op_addr;
      ins_reject <= reject;
      power_state <= next_power;
    end
  end

  // latch, busy flag and protect bits; a new start wins over a done
  always_ff @(posedge clk) begin
    if (srst) begin
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      status_bits <= fwp_pkg::STATUS_RST;
      software_protect_mode <= 1'b0;
      hardware_protect_mode <= 1'b0;
    end else begin
      if (write_enable_cmd_exec) begin
        write_enable_latch <= 1'b1;
      end else if (write_disable_cmd_exec || (op_done && write_in_progress)) begin
        write_enable_latch <= 1'b0;
      end
      write_in_progress <= accept | (write_in_progress & ~op_done);
      if (accept && pend_code == fwp_pkg::cmd_status_write) begin
        status_bits <= next_status;
      end
      software_protect_mode <= cur_region[20:0] != '0;
      hardware_protect_mode <= ~wp_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_latch_needed;
    @(posedge clk) disable iff (srst) op_start |-> $past(write_enable_latch);
  endproperty
  a_latch_needed: assert property (p_latch_needed) else $error("start without latch");

  property p_byte_frame;
    @(posedge clk) disable iff (srst) op_start |-> $past(bit_cnt) == 3'h0;
  endproperty
  a_byte_frame: assert property (p_byte_frame) else $error("start on partial byte");

  property p_deep_quiet;
    @(posedge clk) disable iff (srst) $past(in_deep) |-> !op_start && $stable(write_enable_latch);
  endproperty
  a_deep_quiet: assert property (p_deep_quiet) else $error("work while in deep sleep");

  property p_sleep_enter;
    @(posedge clk) disable iff (srst) sleep_exec |=> power_state == fwp_pkg::pwr_deep;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("deep sleep not entered");

  property p_busy_set;
    @(posedge clk) disable iff (srst) op_start |-> write_in_progress ##1 power_state != fwp_pkg::pwr_standby;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy flag missing");

  property p_done_clears;
    @(posedge clk) disable iff (srst) op_done && write_in_progress |=> !write_enable_latch;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("latch kept after cycle");

  property p_active_low;
    @(posedge clk) disable iff (srst) cs_low && !in_deep |=> power_state == fwp_pkg::pwr_active;
  endproperty
  a_active_low: assert property (p_active_low) else $error("not active while selected");

  property p_hw_freeze;
    @(posedge clk) disable iff (srst) hardware_protect_mode |=> $stable(status_bits);
  endproperty
  a_hw_freeze: assert property (p_hw_freeze) else $error("protect bits changed");

  property p_no_hit;
    @(posedge clk) disable iff (srst) op_start |-> !$past(hit);
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("protected target started");

endmodule

/* File: fwp_top_tb.sv */
// self-checking bench for the write-protect and power-mode block
module fwp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // pins, engine and status
  logic clk, srst, cs_n, sclk, wp_n, ins_valid, op_done, op_start, ins_reject;
  logic write_enable_latch, write_in_progress, software_protect_mode, hardware_protect_mode;
  fwp_pkg::fwp_cmd_t ins_code, op_kind;
  fwp_pkg::fwp_pwr_t power_state;
  logic [19:0] ins_addr, op_addr;
  logic [6:0] ins_status, status_bits;
  int num_errors, check_count, low_cnt, i;
  // commands the model expects the engine to be handed, oldest first
  int exp_q[$];
  bit m_wel, m_deep, m_hw;
  logic [6:0] m_st = 7'h00;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  fwp_top u_dut (.clk, .srst, .cs_n, .sclk, .wp_n, .ins_valid, .ins_code, .ins_addr,
    .ins_status, .op_done, .op_kind, .op_start, .op_addr, .ins_reject, .write_enable_latch,
    .write_in_progress, .status_bits, .power_state, .software_protect_mode,
    .hardware_protect_mode);
  fwp_host u_host (.clk, .cs_n, .sclk, .ins_valid, .ins_code, .ins_addr, .ins_status);
  ////////////////////////////////////////////////////////////////////////
  // protected-byte model: an edge region, inverted by the complement bit
  function automatic bit prot(input logic [6:0] s, input int a);
    int lv, sz;
    lv = int'(s[3:1]);
    if (s[5]) sz = lv == 0 ? 0 : lv < 4 ? 32'h0000_1000 << (lv - 1) : lv < 6 ? 32'h0000_8000 : 32'h0010_0000;
    else sz = lv == 0 ? 0 : lv < 5 ? 32'h0001_0000 << (lv - 1) : 32'h0010_0000;
    return s[6] ^ (s[4] ? a < sz : a >= 32'h0010_0000 - sz);
  endfunction
  // span touched by each array command; status writes touch none
  function automatic int spn(input fwp_pkg::fwp_cmd_t c);
    case (c)
      fwp_pkg::cmd_page_program, fwp_pkg::cmd_quad_page_program: return 32'h0000_0100;
      fwp_pkg::cmd_sector_wipe: return 32'h0000_1000;
      fwp_pkg::cmd_half_block_erase: return 32'h0000_8000;
      fwp_pkg::cmd_block_erase: return 32'h0001_0000;
      fwp_pkg::cmd_chip_erase: return 32'h0010_0000;
      default: return 0;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one framed instruction, compared with the model; engine answers at a random delay
  task automatic do_frame(input fwp_pkg::fwp_cmd_t c, input int n, input int a, input logic [6:0] st);
    int sp, b, k;
    bit md, acc, gs, gr, rj;
    sp = spn(c);
    b = sp != 0 ? a - a % sp : 0;
    md = c inside {[fwp_pkg::cmd_status_write : fwp_pkg::cmd_chip_erase]};
    acc = md && n % 8 == 0 && m_wel && !m_deep && !(sp != 0 && (prot(m_st, b) || prot(m_st, b + sp - 1)));
    // in deep sleep every frame but the wake one is flagged as ignored
    rj = (md && !acc) || (m_deep && c != fwp_pkg::cmd_wake_and_read_id);
    @(posedge clk);
    u_host.frame(c, n, a[19:0], st);
    gs = 0;
    gr = 0;
    for (k = 0; k < 12; k++) begin
      @(negedge clk);
      if (op_start === 1'b1) gs = 1;
      if (ins_reject === 1'b1) gr = 1;
    end
    chk(gs, acc);
    chk(gr, rj);
    if (!m_deep && c == fwp_pkg::cmd_write_enable) m_wel = 1;
    if (!m_deep && c == fwp_pkg::cmd_write_disable) m_wel = 0;
    if (!m_deep && c == fwp_pkg::cmd_deep_sleep_entry) m_deep = 1;
    else if (c == fwp_pkg::cmd_wake_and_read_id) m_deep = 0;
    if (acc) begin
      if (c == fwp_pkg::cmd_status_write && !m_hw) m_st = st;
      chk(write_in_progress, 1);
      chk(power_state, fwp_pkg::pwr_active);
      exp_q.push_back(c);
      chk(op_kind, exp_q.pop_front());
      if (sp != 0) chk(op_addr, a);
      repeat ($urandom_range(1, 6)) @(posedge clk);
      op_done <= 1'b1;
      @(posedge clk);
      op_done <= 1'b0;
      m_wel = 0;
      repeat (2) @(negedge clk);
    end
    chk(write_in_progress, 0);
    chk(write_enable_latch, m_wel);
    chk(status_bits, m_st);
    chk(software_protect_mode, prot(m_st, 0) || prot(m_st, 32'h000F_FFFF));
    chk(hardware_protect_mode, m_hw);
    chk(power_state, m_deep ? fwp_pkg::pwr_deep : fwp_pkg::pwr_standby);
  endtask
  task automatic we();
    do_frame(fwp_pkg::cmd_write_enable, 8, 0, 7'h00);
  endtask
  // a settled selected frame keeps the device active, deep sleep aside
  always @(negedge clk) begin
    low_cnt = cs_n ? 0 : low_cnt + 1;
    if (low_cnt > 4 && !m_deep) chk(power_state, fwp_pkg::pwr_active);
  end
  // hang guard, about twice the expected run
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    op_done = 1'b0;
    void'($urandom(40));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(write_enable_latch, 0);
    chk(power_state, fwp_pkg::pwr_standby);
    do_frame(fwp_pkg::cmd_page_program, 32, 32'h0000_1234, 7'h00);
    we();
    do_frame(fwp_pkg::cmd_sector_wipe, 31, 32'h0000_2000, 7'h00);
    do_frame(fwp_pkg::cmd_write_disable, 8, 0, 7'h00);
    $display("latch and byte-count test done");
    for (i = fwp_pkg::cmd_status_write; i <= fwp_pkg::cmd_chip_erase; i++) begin
      we();
      do_frame(fwp_pkg::fwp_cmd_t'(i), 40, $urandom_range(0, 32'h000F_FFFF), 7'h00);
    end
    $display("command sweep test done");
    for (i = 0; i < 48; i++) begin
      we();
      do_frame(fwp_pkg::cmd_status_write, 16, 0, 7'($urandom));
      we();
      do_frame(fwp_pkg::fwp_cmd_t'($urandom_range(fwp_pkg::cmd_page_program,
        fwp_pkg::cmd_chip_erase)), 32, $urandom_range(0, 32'h000F_FFFF), 7'h00);
    end
    $display("protection test done");
    @(posedge clk);
    wp_n <= 1'b0;
    m_hw = 1;
    repeat (6) @(posedge clk);
    we();
    do_frame(fwp_pkg::cmd_status_write, 16, 0, ~m_st);
    @(posedge clk);
    wp_n <= 1'b1;
    m_hw = 0;
    repeat (6) @(posedge clk);
    $display("hardware protect test done");
    // latch set going in, so the erase below is refused by deep sleep alone
    we();
    do_frame(fwp_pkg::cmd_deep_sleep_entry, 8, 0, 7'h00);
    we();
    do_frame(fwp_pkg::cmd_chip_erase, 8, 0, 7'h00);
    do_frame(fwp_pkg::cmd_wake_and_read_id, 8, 0, 7'h00);
    $display("deep sleep test done");
    complete_run();
  end
endmodule
